// [design/tcc_pkg.sv]
package tcc_pkg;

	// Register byte addresses; unit n value low at VAL_BASE + 8n, high 4 above it.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MODE = 8'h04;
	localparam logic [7:0] REG_TLO = 8'h08;
	localparam logic [7:0] REG_THI = 8'h0c;
	localparam logic [7:0] REG_VAL_BASE = 8'h10;
	localparam logic [7:0] REG_VAL_STEP = 8'h08;
	localparam logic [7:0] REG_VAL_HI = 8'h04;
	localparam logic [7:0] REG_PORT = 8'h30;
	localparam logic [7:0] REG_PIN = 8'h34;
	localparam logic [7:0] REG_IEN = 8'h38;

	// Field positions of the timer control register.
	localparam int CTRL_PS = 7;
	localparam int CTRL_PSM = 6;
	localparam int CTRL_SIZE = 5;
	localparam int CTRL_CM = 2;
	localparam int CTRL_IN1 = 1;
	localparam int CTRL_IN0 = 0;

	// Reset values.
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [15:0] TIMER_RST = 16'h0000;
	localparam logic [15:0] VAL_RST = 16'h0000;
	localparam logic [3:0] PORT_RST = 4'h0;
	localparam logic [3:0] IEN_RST = 4'h0;

	// Timer increment dividers, in pclk cycles per count.
	localparam logic [4:0] DIV_CLK = 5'h02;
	localparam logic [4:0] DIV_LO = 5'h0c;
	localparam logic [4:0] DIV_HI = 5'h18;

	localparam logic [7:0] LOW_MAX = 8'hff;
	localparam logic [15:0] FULL_MAX = 16'hffff;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_CAP_PIN = 2'b01,
		MODE_CMP = 2'b10,
		MODE_CAP_WR = 2'b11
	} tcc_mode_e;

	typedef enum logic [1:0] {
		SRC_STOP = 2'b00,
		SRC_OSC = 2'b01,
		SRC_EXT = 2'b10,
		SRC_EXT_ALT = 2'b11
	} tcc_src_e;

endpackage : tcc_pkg

// [design/tcc_capcmp.sv]
// Operation
// - Pin 0 falling edge; pins 1,2 rising edge.
// - Capture copies the full 16-bit timer.
// - Capture never disturbs the running timer.
// - Pin-edge mode latches timer on configured edge in units 0 to 2; unit 3 has no pin.
// - Write-trigger mode captures on low byte write.
// - Capture modes raise no interrupt request.
// - Compare only with mode bits high one, low zero.
// - Pin changes with the compare signal itself.
// - One control bit selects compare mode 0 or 1.
// - Mode 0: match drives compare high, interrupts.
// - Mode 0: timer overflow forces pin low.
// - Mode 1: port write reaches pin at match.
// - Mode 1: match also requests the interrupt.
// - Each compare unit owns one interrupt line.
// - Mode 0 PWM pin ignores port writes.
// - Unit n drives port-one bit n.
// - PWM low while value exceeds the timer.
// - Timer equal to value switches PWM high.
// - Input-select bits choose timer increment source.
// - Width bit: one gives 8-bit, zero 16-bit.
// - 8-bit compares low bytes; 16-bit whole words.
// - PWM period is 256 or 65536 counts.
// - Prescale twelfth or twenty-fourth, or clock half.
// - Mode field: off, pin capture, compare, write capture.
// - Only unit 0 supplies the reload value.
`timescale 1ns/1ps
`default_nettype none

module tcc_capcmp #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_pin_zero,
	input wire logic capture_pin_one,
	input wire logic capture_pin_two,
	input wire logic timer_count_pin,
	output logic [3:0] port_one,
	output logic [3:0] compare_irq_n,
	output logic [15:0] reload_value
);

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [15:0] timer;
		logic [3:0][15:0] val;
		logic [3:0] port;
		logic [3:0] ien;
		logic [4:0] pre_cnt;
		logic [3:0] cmp;
		logic [3:0] hold;
		logic [3:0] pin;
		logic [3:0] irq;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] sync3;
		logic [3:0] flt;
		logic [31:0] rdata;
	} tcc_state_s;

	tcc_state_s st_ff;
	tcc_state_s nxt_st;

	logic [3:0] pin_raw;
	logic [3:0] stable;
	logic [3:0] rise;
	logic [3:0] fall;
	logic [3:0] cap;
	logic [3:0] hit;
	logic [3:0] eq_now;
	logic [3:0] eq_next;
	logic [3:0] wr_low;
	logic [3:0] wr_high;
	logic [3:0] cmp_unit;
	logic [15:0] timer_inc;
	logic [4:0] div;
	logic pre_tick;
	logic tick;
	logic ovf;
	logic wr_en;
	logic wr_tlo;
	logic wr_thi;
	logic size8;
	logic cm1;

	function automatic logic [1:0] unit_mode(input logic [7:0] cfg, input int n);
		unit_mode = cfg[2*n +: 2];
	endfunction : unit_mode

	function automatic logic [7:0] val_addr(input int n, input logic hi);
		val_addr = 8'(int'(tcc_pkg::REG_VAL_BASE) + n * int'(tcc_pkg::REG_VAL_STEP)
			+ (hi ? int'(tcc_pkg::REG_VAL_HI) : 0));
	endfunction : val_addr

	function automatic logic is_equal(input logic [15:0] t, input logic [15:0] v,
		input logic narrow);
		is_equal = narrow ? (t[7:0] == v[7:0]) : (t == v);
	endfunction : is_equal

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == tcc_pkg::REG_CTRL) || (a == tcc_pkg::REG_MODE) ||
			(a == tcc_pkg::REG_TLO) || (a == tcc_pkg::REG_THI) ||
			(a == tcc_pkg::REG_PORT) || (a == tcc_pkg::REG_PIN) ||
			(a == tcc_pkg::REG_IEN) ||
			(a >= tcc_pkg::REG_VAL_BASE && a < tcc_pkg::REG_PORT && a[1:0] == 2'h0);
	endfunction : is_mapped

	function automatic logic [31:0] read_mux(input tcc_state_s s, input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (a)
			tcc_pkg::REG_CTRL: d[7:0] = s.ctrl;
			tcc_pkg::REG_MODE: d[7:0] = s.mode;
			tcc_pkg::REG_TLO: d[7:0] = s.timer[7:0];
			tcc_pkg::REG_THI: d[7:0] = s.timer[15:8];
			tcc_pkg::REG_PORT: d[3:0] = s.port;
			tcc_pkg::REG_PIN: d[3:0] = s.pin;
			tcc_pkg::REG_IEN: d[3:0] = s.ien;
			default:
			begin
				for (int n = 0; n < 4; n++)
				begin
					if (a == val_addr(n, 1'b0))
						d[7:0] = s.val[n][7:0];
					if (a == val_addr(n, 1'b1))
						d[7:0] = s.val[n][15:8];
				end
			end
		endcase
		read_mux = d;
	endfunction : read_mux

	assign pin_raw = {timer_count_pin, capture_pin_two, capture_pin_one, capture_pin_zero};

	// A change counts once the second and third stages agree.
	assign stable = ~(st_ff.sync2 ^ st_ff.sync3);
	assign rise = stable & st_ff.sync3 & ~st_ff.flt;
	assign fall = stable & ~st_ff.sync3 & st_ff.flt;

	assign size8 = st_ff.ctrl[tcc_pkg::CTRL_SIZE];
	assign cm1 = st_ff.ctrl[tcc_pkg::CTRL_CM];

	assign div = st_ff.ctrl[tcc_pkg::CTRL_PSM] ? tcc_pkg::DIV_CLK :
		(st_ff.ctrl[tcc_pkg::CTRL_PS] ? tcc_pkg::DIV_HI : tcc_pkg::DIV_LO);
	assign pre_tick = (st_ff.pre_cnt >= div - 5'h01);

	always_comb
	begin
		case (tcc_pkg::tcc_src_e'(st_ff.ctrl[tcc_pkg::CTRL_IN1:tcc_pkg::CTRL_IN0]))
			tcc_pkg::SRC_OSC: tick = pre_tick;
			tcc_pkg::SRC_EXT: tick = rise[3];
			tcc_pkg::SRC_EXT_ALT: tick = rise[3];
			default: tick = 1'b0;
		endcase
	end

	// An 8-bit timer wraps its low byte alone, so its period is 256 counts.
	assign ovf = tick && (size8 ? (st_ff.timer[7:0] == tcc_pkg::LOW_MAX) :
		(st_ff.timer == tcc_pkg::FULL_MAX));
	assign timer_inc = size8 ? {st_ff.timer[15:8], st_ff.timer[7:0] + 8'h01} :
		st_ff.timer + 16'h0001;

	assign wr_en = psel && penable && pwrite;
	assign wr_tlo = wr_en && (8'(paddr) == tcc_pkg::REG_TLO);
	assign wr_thi = wr_en && (8'(paddr) == tcc_pkg::REG_THI);

	always_comb
	begin
		for (int n = 0; n < 4; n++)
		begin
			wr_low[n] = wr_en && (8'(paddr) == val_addr(n, 1'b0));
			wr_high[n] = wr_en && (8'(paddr) == val_addr(n, 1'b1));
			cmp_unit[n] = (unit_mode(st_ff.mode, n) == tcc_pkg::MODE_CMP);
			eq_now[n] = is_equal(st_ff.timer, st_ff.val[n], size8);
			eq_next[n] = is_equal(nxt_st.timer, nxt_st.val[n], size8);
			hit[n] = cmp_unit[n] && eq_next[n] && !eq_now[n];
		end
		cap[0] = (unit_mode(st_ff.mode, 0) == tcc_pkg::MODE_CAP_PIN) && fall[0];
		cap[1] = (unit_mode(st_ff.mode, 1) == tcc_pkg::MODE_CAP_PIN) && rise[1];
		cap[2] = (unit_mode(st_ff.mode, 2) == tcc_pkg::MODE_CAP_PIN) && rise[2];
		cap[3] = 1'b0;
		for (int n = 0; n < 4; n++)
			if (unit_mode(st_ff.mode, n) == tcc_pkg::MODE_CAP_WR && wr_low[n])
				cap[n] = 1'b1;
	end

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.sync1 = pin_raw;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.sync3 = st_ff.sync2;
		for (int n = 0; n < 4; n++)
			if (stable[n])
				nxt_st.flt[n] = st_ff.sync3[n];
		nxt_st.pre_cnt = pre_tick ? 5'h00 : st_ff.pre_cnt + 5'h01;
		// A software write to the timer wins over the count in the same cycle.
		if (tick)
			nxt_st.timer = timer_inc;
		if (wr_tlo)
			nxt_st.timer[7:0] = pwdata[7:0];
		if (wr_thi)
			nxt_st.timer[15:8] = pwdata[7:0];
		if (wr_en && 8'(paddr) == tcc_pkg::REG_CTRL)
			nxt_st.ctrl = pwdata[7:0];
		if (wr_en && 8'(paddr) == tcc_pkg::REG_MODE)
			nxt_st.mode = pwdata[7:0];
		if (wr_en && 8'(paddr) == tcc_pkg::REG_PORT)
			nxt_st.port = pwdata[3:0];
		if (wr_en && 8'(paddr) == tcc_pkg::REG_IEN)
			nxt_st.ien = pwdata[3:0];
		for (int n = 0; n < 4; n++)
		begin
			if (wr_low[n])
				nxt_st.val[n][7:0] = pwdata[7:0];
			if (wr_high[n])
				nxt_st.val[n][15:8] = pwdata[7:0];
			// The captured count overrides the byte that triggered it.
			if (cap[n])
				nxt_st.val[n] = st_ff.timer;
		end
		for (int n = 0; n < 4; n++)
		begin
			if (cmp_unit[n] && eq_next[n])
				nxt_st.cmp[n] = 1'b1;
			else if (ovf)
				nxt_st.cmp[n] = 1'b0;
			if (hit[n])
				nxt_st.hold[n] = st_ff.port[n];
			nxt_st.irq[n] = hit[n] && st_ff.ien[n];
			// Pin takes its new level on the same edge as the compare signal.
			if (!cmp_unit[n])
				nxt_st.pin[n] = nxt_st.port[n];
			else if (cm1)
				nxt_st.pin[n] = nxt_st.hold[n];
			else
				nxt_st.pin[n] = nxt_st.cmp[n];
		end
		if (psel && !penable)
			nxt_st.rdata = read_mux(st_ff, 8'(paddr));
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff <= '0;
			st_ff.ctrl <= tcc_pkg::CTRL_RST;
			st_ff.mode <= tcc_pkg::MODE_RST;
			st_ff.timer <= tcc_pkg::TIMER_RST;
			st_ff.val <= {4{tcc_pkg::VAL_RST}};
			st_ff.port <= tcc_pkg::PORT_RST;
			st_ff.pin <= tcc_pkg::PORT_RST;
			st_ff.hold <= tcc_pkg::PORT_RST;
			st_ff.ien <= tcc_pkg::IEN_RST;
		end
		else
			st_ff <= nxt_st;
	end

	// Zero-wait slave: read data is fetched in the setup cycle.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !is_mapped(8'(paddr));
	assign prdata = st_ff.rdata;
	assign port_one = st_ff.pin;
	assign compare_irq_n = ~st_ff.irq;
	assign reload_value = st_ff.val[0];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_pin0_fall;
		(st_ff.sync3[0] == st_ff.sync2[0]) && !st_ff.sync3[0] && st_ff.flt[0];
	endsequence

	sequence s_pin_mode0;
		unit_mode(st_ff.mode, 0) == tcc_pkg::MODE_CAP_PIN;
	endsequence

	a_cap_pin_zero: assert property (s_pin_mode0 and s_pin0_fall |=>
		st_ff.val[0] == $past(st_ff.timer))
		else $error("unit 0 missed a falling-edge capture");

	a_cap_full_word: assert property (cap[1] |=> st_ff.val[1] == $past(st_ff.timer))
		else $error("capture did not copy the full timer");

	a_cap_no_disturb: assert property (cap != 4'h0 && !wr_tlo && !wr_thi
		|=> st_ff.timer == $past(tick ? timer_inc : st_ff.timer))
		else $error("capture disturbed the timer");

	a_cap_write_trig: assert property (unit_mode(st_ff.mode, 2) == tcc_pkg::MODE_CAP_WR
		&& wr_low[2] |=> st_ff.val[2] == $past(st_ff.timer))
		else $error("low byte write did not capture");

	a_cap_no_irq: assert property (st_ff.mode[2] |=> compare_irq_n[1])
		else $error("capture unit raised an interrupt");

	a_unit3_no_pin: assert property (unit_mode(st_ff.mode, 3) == tcc_pkg::MODE_CAP_PIN
		&& !wr_low[3] && !wr_high[3] |=> $stable(st_ff.val[3]))
		else $error("unit 3 captured from a pin");

	a_mode0_pin: assert property (cmp_unit[0] && !cm1 |-> port_one[0] == st_ff.cmp[0]
		|| $changed(st_ff.mode) || $changed(st_ff.ctrl))
		else $error("mode 0 pin differs from compare signal");

	a_cmp_set: assert property (cmp_unit[0] && eq_next[0] |=> st_ff.cmp[0])
		else $error("compare signal not set on match");

	a_ovf_clear: assert property (ovf && !eq_next[1] && !wr_tlo && !wr_thi
		&& !wr_low[1] && !wr_high[1] |=> !st_ff.cmp[1])
		else $error("overflow did not clear compare signal");

	a_mode1_hold: assert property (hit[1] && cm1
		|=> port_one[1] == $past(st_ff.port[1]))
		else $error("mode 1 pin did not take the port value at match");

	a_mode1_irq: assert property (hit[1] && cm1 && st_ff.ien[1] |=> !compare_irq_n[1]
		##1 compare_irq_n[1] || hit[1])
		else $error("mode 1 match gave no single interrupt pulse");

	a_wide_eq: assert property (!size8 && cmp_unit[1] && eq_next[1] && !eq_now[1]
		|-> nxt_st.timer == nxt_st.val[1])
		else $error("16-bit compare matched on part of the word");

	a_clk_half: assert property (st_ff.ctrl[tcc_pkg::CTRL_PSM] && pre_tick &&
		$stable(st_ff.ctrl) && !(wr_en && 8'(paddr) == tcc_pkg::REG_CTRL)
		|=> !pre_tick ##1 (pre_tick || $changed(st_ff.ctrl)))
		else $error("clock-half prescale period wrong");

	a_pwm_low_hold: assert property (cmp_unit[1] && !st_ff.cmp[1] && !eq_next[1]
		|=> !st_ff.cmp[1])
		else $error("compare signal rose without a match");

	a_pwm_port_ign: assert property (cmp_unit[1] && !cm1
		|=> port_one[1] == st_ff.cmp[1])
		else $error("port write reached a mode 0 pin");

	a_port_map: assert property (!cmp_unit[2]
		|=> port_one[2] == st_ff.port[2])
		else $error("port bit did not reach its own pin");

	a_narrow_high: assert property (size8 && !wr_thi
		|=> st_ff.timer[15:8] == $past(st_ff.timer[15:8]))
		else $error("8-bit timer carried into its high byte");

	a_low_wrap: assert property (tick && !wr_tlo && !wr_thi
		&& st_ff.timer[7:0] == tcc_pkg::LOW_MAX |=> st_ff.timer[7:0] == 8'h00)
		else $error("timer low byte did not wrap to zero");

	a_irq_cmp_only: assert property (!cmp_unit[2] |=> compare_irq_n[2])
		else $error("non-compare unit raised an interrupt");

	a_unit_off: assert property (unit_mode(st_ff.mode, 3) == tcc_pkg::MODE_OFF
		&& !wr_low[3] && !wr_high[3] |=> $stable(st_ff.val[3]))
		else $error("disabled unit changed its value");

	a_src_stop: assert property (!st_ff.ctrl[tcc_pkg::CTRL_IN1]
		&& !st_ff.ctrl[tcc_pkg::CTRL_IN0] |-> !tick)
		else $error("stopped timer source still ticked");

endmodule : tcc_capcmp

`default_nettype wire

// [dv/tcc_partner.sv]
`timescale 1ns/1ps
`default_nettype none

module tcc_partner (
	input wire logic pclk,
	output logic capture_pin_zero,
	output logic capture_pin_one,
	output logic capture_pin_two,
	output logic timer_count_pin
);
	initial
	begin
		capture_pin_zero = 1'b1;
		capture_pin_one = 1'b0;
		capture_pin_two = 1'b0;
		timer_count_pin = 1'b0;
	end

	// Pin 0 idles high so that its trigger is a fall, pins 1 and 2 idle low.
	// Going back to idle makes the opposite edge, which must not capture.
	task automatic drive(input logic active);
		@(posedge pclk);
		capture_pin_zero <= ~active;
		capture_pin_one <= active;
		capture_pin_two <= active;
	endtask : drive

	// Pulses are held for four cycles so that they survive the input synchroniser.
	task automatic count(input int n);
		repeat (n)
		begin
			repeat (4) @(posedge pclk);
			timer_count_pin <= 1'b1;
			repeat (4) @(posedge pclk);
			timer_count_pin <= 1'b0;
		end
	endtask : count
endmodule : tcc_partner

`default_nettype wire

// [dv/timer2_capture_compare_pwm_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module timer2_capture_compare_pwm_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cp0;
	logic cp1;
	logic cp2;
	logic cnt;
	logic [3:0] port_one;
	logic [3:0] compare_irq_n;
	logic [15:0] reload_value;
	logic [31:0] rdat;
	logic rerr;
	logic [15:0] v;
	logic [15:0] got;
	logic [15:0] exp_val [4];
	int miscompares = 0;
	int cmp_count = 0;
	int irqs = 0;
	int base;
	int h0;
	int h1;
	int cfg [3][2] = '{'{8'h61, 2}, '{8'h21, 12}, '{8'ha1, 24}};

	always #12.5 pclk = ~pclk;
	// Outputs are unknown before the first reset edge, so counting waits for release.
	always @(posedge pclk)
		if (presetn)
			irqs <= irqs + 4 - $countones(compare_irq_n);

	tcc_capcmp u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_pin_zero(cp0), .capture_pin_one(cp1),
		.capture_pin_two(cp2), .timer_count_pin(cnt), .port_one(port_one),
		.compare_irq_n(compare_irq_n), .reload_value(reload_value));
	tcc_partner u_far (.pclk(pclk), .capture_pin_zero(cp0), .capture_pin_one(cp1),
		.capture_pin_two(cp2), .timer_count_pin(cnt));

	// Model of the PWM high time, in pclk cycles, for one 8-bit period.
	function automatic int pwm_high(input int val, input int div);
		return (256 - val) * div;
	endfunction : pwm_high

	function automatic logic [7:0] vaddr(input int n);
		return tcc_pkg::REG_VAL_BASE + 8'(8 * n);
	endfunction : vaddr

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// High byte first, so a running timer never passes the match while half written.
	task automatic settm(input logic [15:0] t);
		apb(1'b1, tcc_pkg::REG_THI, 32'(t[15:8]));
		apb(1'b1, tcc_pkg::REG_TLO, 32'(t[7:0]));
	endtask : settm

	task automatic setv(input int n, input logic [15:0] t);
		apb(1'b1, vaddr(n), 32'(t[7:0]));
		apb(1'b1, vaddr(n) + tcc_pkg::REG_VAL_HI, 32'(t[15:8]));
	endtask : setv

	task automatic getv(input int n);
		apb(1'b0, vaddr(n), 0);
		got[7:0] = rdat[7:0];
		apb(1'b0, vaddr(n) + tcc_pkg::REG_VAL_HI, 0);
		got[15:8] = rdat[7:0];
	endtask : getv

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick

	task automatic measure(input int n);
		h0 = 0;
		h1 = 0;
		repeat (n)
		begin
			tick(1);
			h0 += (port_one[0] === 1'b1);
			h1 += (port_one[1] === 1'b1);
		end
	endtask : measure

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	initial
	begin
		#(60000 * 25);
		miscompares++;
		stop_test;
	end

	initial
	begin
		void'($urandom(21345));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, tcc_pkg::REG_CTRL, 0);
		chk(rdat, 32'(tcc_pkg::CTRL_RST));
		apb(1'b0, tcc_pkg::REG_MODE, 0);
		chk(rdat, 32'(tcc_pkg::MODE_RST));
		chk(pready, 1'b1);
		apb(1'b0, 8'hfc, 0);
		chk(rerr, 1'b1);
		chk(rdat, 0);
		apb(1'b1, tcc_pkg::REG_IEN, 32'hf);
		apb(1'b1, tcc_pkg::REG_MODE, 32'hff);
		for (int n = 0; n < 4; n++)
		begin
			v = 16'($urandom);
			settm(v);
			apb(1'b1, vaddr(n), 32'($urandom) & 32'hff);
			getv(n);
			chk(got, v);
			exp_val[n] = v;
			apb(1'b0, tcc_pkg::REG_THI, 0);
			chk(rdat, 32'(v[15:8]));
		end
		chk(reload_value, exp_val[0]);
		// Disabled units first, then pin capture; the idle return must not capture.
		for (int m = 0; m < 2; m++)
		begin
			apb(1'b1, tcc_pkg::REG_MODE, m ? 32'h55 : 32'h00);
			settm(16'ha5c3);
			u_far.drive(1'b1);
			tick(10);
			settm(16'h3c5a);
			u_far.drive(1'b0);
			tick(10);
			for (int n = 0; n < 4; n++)
			begin
				getv(n);
				chk(got, (m && n < 3) ? 16'ha5c3 : exp_val[n]);
			end
		end
		chk(irqs, 0);
		apb(1'b1, tcc_pkg::REG_MODE, 32'h00);
		// Both external selections count the pin, each with its own pulse count.
		for (int s = 2; s < 4; s++)
		begin
			apb(1'b1, tcc_pkg::REG_CTRL, 32'(s));
			settm(16'h0000);
			u_far.count(s + 3);
			tick(10);
			apb(1'b0, tcc_pkg::REG_TLO, 0);
			chk(rdat, s + 3);
		end
		apb(1'b1, tcc_pkg::REG_CTRL, 32'h04);
		apb(1'b1, tcc_pkg::REG_MODE, 32'h08);
		setv(1, 16'h1234);
		settm(16'h1230);
		apb(1'b1, tcc_pkg::REG_PORT, 32'h2);
		tick(10);
		chk(port_one[1], 1'b0);
		base = irqs;
		apb(1'b1, tcc_pkg::REG_CTRL, 32'h45);
		tick(20);
		chk(port_one[1], 1'b1);
		chk(irqs - base, 1);
		apb(1'b1, tcc_pkg::REG_CTRL, 32'h41);
		settm(16'hfff0);
		tick(50);
		chk(port_one[1], 1'b0);
		settm(16'h0030);
		base = irqs;
		tick(20);
		chk(port_one[1], 1'b0);
		settm(16'h1230);
		tick(20);
		chk(port_one[1], 1'b1);
		chk(irqs - base, 1);
		apb(1'b1, tcc_pkg::REG_MODE, 32'h0a);
		setv(0, 16'h00e6);
		setv(1, 16'h7fc0);
		apb(1'b1, tcc_pkg::REG_PORT, 32'hf);
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, tcc_pkg::REG_CTRL, cfg[i][0]);
			tick(256 * cfg[i][1]);
			base = irqs;
			measure(256 * cfg[i][1]);
			chk(h0, pwm_high(8'he6, cfg[i][1]));
			chk(h1, pwm_high(8'hc0, cfg[i][1]));
			chk(irqs - base, 2);
		end
		chk(port_one[3:2], 2'b11);
		stop_test;
	end
endmodule : timer2_capture_compare_pwm_bench

`default_nettype wire
